// ==== core/sas_pkg.sv ====
// Constants, field positions and encodings for the converter sequencer.
// Assumes one 250 MHz system clock and a byte-wide register port.
// Contract
// - Single step converts one channel per start
// - Single step stores result by channel index
// - Mode bits 6:5:4 pick conversion mode
// - Timer overflow starts; overflows ignored while busy
// - Code 00 with timer select else stopped
// - Writing code 01 starts conversion at once
// - Pin edge starts; edges ignored while busy
// - Every start method works with every mode
// - Early nibble limit check after four bits
// - Full eight-bit limit check if nibble inside
// - Limit interrupt enable gates limit request
// - Holding register drives output when enabled
// - Clock divider one to eight forms converter clock
// - Selected pins lose digital input when enabled
// - Keeps running in idle, completion wakes
// - No conversion in power-down modes
// - Enable bit activates converter and output
// - Done flag set by hardware, cleared by write
// - Done interrupt enable gates completion request
// - Divisor field value plus one divides clock
// - Limit flag shows result outside limits
// - Check-all bit else only input zero
// - Select bits 7:4 pick inputs 3:0
package sas_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] SAS_ADDR_CTRL = 8'h97;
  localparam logic [7:0] SAS_ADDR_MODE_A = 8'hc0;
  localparam logic [7:0] SAS_ADDR_MODE_B = 8'ha1;
  localparam logic [7:0] SAS_ADDR_CHSEL = 8'ha3;
  localparam logic [7:0] SAS_ADDR_LIM_HI = 8'ha4;
  localparam logic [7:0] SAS_ADDR_LIM_LO = 8'ha5;
  localparam logic [7:0] SAS_ADDR_DAC = 8'ha6;
  localparam logic [7:0] SAS_ADDR_RES0 = 8'ha8;
  localparam logic [7:0] SAS_RST_REG = 8'h00;
  localparam logic [7:0] SAS_RST_LIM_HI = 8'hff;
  // ==========================================================
  // Field positions and writable masks
  localparam int SAS_CTRL_LIM_IE = 7;
  localparam int SAS_CTRL_DONE_IE = 6;
  localparam int SAS_CTRL_TMR_SEL = 5;
  localparam int SAS_CTRL_DONE = 3;
  localparam int SAS_CTRL_EN = 2;
  localparam int SAS_MODEA_LIM_FLAG = 7;
  localparam int SAS_MODEB_DAC_OE = 3;
  localparam int SAS_MODEB_CHK_ALL = 1;
  localparam logic [7:0] SAS_CTRL_WMASK = 8'he7;
  localparam logic [7:0] SAS_MODEA_WMASK = 8'h70;
  localparam logic [7:0] SAS_MODEB_WMASK = 8'hea;
  localparam logic [7:0] SAS_CHSEL_WMASK = 8'hf0;
  localparam logic [2:0] SAS_NIB_IDX = 3'h4;
  localparam logic [1:0] SAS_LAST_SLOT = 2'h3;
  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    SAS_SC_TIMER = 2'b00,
    SAS_SC_NOW = 2'b01,
    SAS_SC_RSVD = 2'b10,
    SAS_SC_EDGE = 2'b11
  } sas_start_t;
  typedef enum logic [2:0] {
    SAS_MD_STEP = 3'b000,
    SAS_MD_PASS = 3'b001,
    SAS_MD_CONT = 3'b010,
    SAS_MD_SCAN = 3'b100
  } sas_mode_t;
  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_SAMPLE = 2'b01,
    SAS_CONVERT = 2'b10
  } sas_state_t;
endpackage : sas_pkg

// ==== core/sas_sequencer.sv ====
// Sequencer for an 8-bit four-input successive-approximation converter.
// Assumes an outside comparator that reports input >= trial code each cycle.
//
// Design decision made here: strobed register access.
module sas_sequencer
  import sas_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic timer0_ovf,
  input wire logic edge_trigger_pin,
  input wire logic idle_mode,
  input wire logic power_down,
  input wire logic comp_ge,
  output logic sample_hold,
  output logic [1:0] mux_channel,
  output logic [7:0] sar_trial,
  output logic busy,
  output logic [3:0] dig_in_disconnect,
  output logic [7:0] dac_output_pin,
  output logic dac_drive,
  output logic irq_req,
  output logic idle_wake
);
  // ==========================================================
  // Helpers
  function automatic logic [1:0] sas_first(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (m[i])
        r = 2'(i);
    end
    return r;
  endfunction : sas_first

  function automatic logic sas_outside(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi);
    return (v > hi) || (v < lo);
  endfunction : sas_outside

  // ==========================================================
  // Registers
  logic [7:0] ctrl_r, mode_a_r, mode_b_r, chsel_r, lim_hi_r, lim_lo_r, dac_r;
  logic [7:0] res_r [4];
  logic [7:0] rdata_r;
  sas_state_t st_r, st_nxt;
  logic [1:0] ch_r, ch_nxt, slot_r, slot_nxt;
  logic [3:0] pend_r, pend_nxt;
  logic [7:0] sar_r;
  logic [2:0] bit_r;
  logic [2:0] div_cnt_r;
  logic early_hit_r, edge_prev_r;
  logic sample_r, busy_r;
  logic [3:0] dig_r;
  logic dac_drive_r, irq_r, wake_r;

  logic wr_ctrl, wr_mode_a, run_ok, stop_code, go, tick, conv_end, done_evt, lim_evt;
  logic trig_timer, trig_now, trig_edge, chk_ok;
  logic [3:0] src, two_rest;
  logic [1:0] pick_ch, first_c, second_c, res_idx;
  logic [7:0] dv;
  sas_mode_t mode;
  sas_start_t scode;

  assign wr_ctrl = reg_wr && (reg_addr == ADDR_W'(SAS_ADDR_CTRL));
  assign wr_mode_a = reg_wr && (reg_addr == ADDR_W'(SAS_ADDR_MODE_A));
  assign mode = sas_mode_t'(mode_a_r[6:4]);
  assign scode = sas_start_t'(ctrl_r[1:0]);

  // ==========================================================
  // Start triggers, all usable in every mode
  // stop code when timer select clear
  assign stop_code = (scode == SAS_SC_TIMER) && !ctrl_r[SAS_CTRL_TMR_SEL];
  assign trig_timer = (scode == SAS_SC_TIMER) && ctrl_r[SAS_CTRL_TMR_SEL] && timer0_ovf;
  // Start is taken from the write itself, so the code needs no self-clear
  assign trig_now = wr_ctrl && (reg_wdata[1:0] == SAS_SC_NOW);
  assign trig_edge = (scode == SAS_SC_EDGE) && (edge_trigger_pin != edge_prev_r);
  // DAC mode borrows the converter, so no sampling while it drives out
  assign run_ok = ctrl_r[SAS_CTRL_EN] && !power_down && !mode_b_r[SAS_MODEB_DAC_OE]
                  && (chsel_r[7:4] != 4'h0);
  // Triggers count only from idle; while busy they fall away
  assign go = (st_r == SAS_IDLE) && run_ok && (trig_timer || trig_now || trig_edge);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      edge_prev_r <= 1'b0;
    else
      edge_prev_r <= edge_trigger_pin;
  end

  // ==========================================================
  // Converter clock divider
  assign tick = (div_cnt_r == 3'h0);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      div_cnt_r <= 3'h0;
    else if (st_r == SAS_IDLE || tick)
      div_cnt_r <= mode_b_r[7:5];
    else
      div_cnt_r <= 3'(div_cnt_r - 3'h1);
  end

  // ==========================================================
  // Channel choice
  assign src = (pend_r == 4'h0) ? chsel_r[7:4] : pend_r;
  assign pick_ch = sas_first(src);
  assign first_c = sas_first(chsel_r[7:4]);
  assign two_rest = chsel_r[7:4] & ~(4'h1 << first_c);
  assign second_c = sas_first(two_rest);
  assign dv = comp_ge ? sar_r : (sar_r & ~(8'h01 << bit_r));
  assign conv_end = (st_r == SAS_CONVERT) && tick && (bit_r == 3'h0);
  assign res_idx = (mode == SAS_MD_CONT) ? slot_r : ch_r;

  // ==========================================================
  // Sequencing
  always_comb
  begin
    st_nxt = st_r;
    ch_nxt = ch_r;
    pend_nxt = pend_r;
    slot_nxt = slot_r;
    done_evt = 1'b0;
    if (st_r != SAS_IDLE && (!run_ok || stop_code))
    begin
      st_nxt = SAS_IDLE;
      pend_nxt = 4'h0;
    end
    else
    begin
      case (st_r)
        SAS_IDLE:
        begin
          if (go)
          begin
            st_nxt = SAS_SAMPLE;
            if (mode == SAS_MD_CONT)
            begin
              ch_nxt = first_c;
              slot_nxt = 2'h0;
            end
            else
            begin
              ch_nxt = pick_ch;
              pend_nxt = src & ~(4'h1 << pick_ch);
            end
          end
        end
        SAS_SAMPLE:
        begin
          if (tick)
            st_nxt = SAS_CONVERT;
        end
        SAS_CONVERT:
        begin
          if (conv_end)
          begin
            case (mode)
              SAS_MD_PASS:
              begin
                if (pend_r != 4'h0)
                begin
                  st_nxt = SAS_SAMPLE;
                  ch_nxt = pick_ch;
                  pend_nxt = src & ~(4'h1 << pick_ch);
                end
                else
                begin
                  st_nxt = SAS_IDLE;
                  done_evt = 1'b1;
                end
              end
              SAS_MD_SCAN:
              begin
                st_nxt = SAS_SAMPLE;
                ch_nxt = pick_ch;
                pend_nxt = src & ~(4'h1 << pick_ch);
                done_evt = (pend_r == 4'h0);
              end
              SAS_MD_CONT:
              begin
                st_nxt = SAS_SAMPLE;
                slot_nxt = 2'(slot_r + 2'h1);
                // Dual channel alternates; fixed channel repeats
                ch_nxt = (!slot_r[0] && two_rest != 4'h0) ? second_c : first_c;
                done_evt = (slot_r == SAS_LAST_SLOT);
              end
              default:
              begin
                st_nxt = SAS_IDLE;
                done_evt = 1'b1;
              end
            endcase
          end
        end
        default:
          st_nxt = SAS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= SAS_IDLE;
      ch_r <= 2'h0;
      pend_r <= 4'h0;
      slot_r <= 2'h0;
    end
    else
    begin
      st_r <= st_nxt;
      ch_r <= ch_nxt;
      pend_r <= pend_nxt;
      slot_r <= slot_nxt;
    end
  end

  // ==========================================================
  // Successive approximation and limit check
  assign chk_ok = mode_b_r[SAS_MODEB_CHK_ALL] || (ch_r == 2'h0);
  always_comb
  begin
    lim_evt = 1'b0;
    if (st_r == SAS_CONVERT && tick && chk_ok && run_ok && !stop_code)
    begin
      if (bit_r == SAS_NIB_IDX)
        lim_evt = sas_outside({4'h0, dv[7:4]}, {4'h0, lim_lo_r[7:4]},
                              {4'h0, lim_hi_r[7:4]});
      else if (bit_r == 3'h0 && !early_hit_r)
        lim_evt = sas_outside(dv, lim_lo_r, lim_hi_r);
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sar_r <= 8'h80;
      bit_r <= 3'h7;
      early_hit_r <= 1'b0;
    end
    else if (st_r == SAS_SAMPLE)
    begin
      sar_r <= 8'h80;
      bit_r <= 3'h7;
      early_hit_r <= 1'b0;
    end
    else if (st_r == SAS_CONVERT && tick && bit_r != 3'h0)
    begin
      sar_r <= dv | (8'h01 << 3'(bit_r - 3'h1));
      bit_r <= 3'(bit_r - 3'h1);
      if (lim_evt)
        early_hit_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        res_r[i] <= SAS_RST_REG;
    end
    else if (conv_end && run_ok && !stop_code)
      res_r[res_idx] <= dv;
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_b_r <= SAS_RST_REG;
      chsel_r <= SAS_RST_REG;
      lim_hi_r <= SAS_RST_LIM_HI;
      lim_lo_r <= SAS_RST_REG;
      dac_r <= SAS_RST_REG;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_W'(SAS_ADDR_MODE_B): mode_b_r <= reg_wdata & SAS_MODEB_WMASK;
        ADDR_W'(SAS_ADDR_CHSEL): chsel_r <= reg_wdata & SAS_CHSEL_WMASK;
        ADDR_W'(SAS_ADDR_LIM_HI): lim_hi_r <= reg_wdata;
        ADDR_W'(SAS_ADDR_LIM_LO): lim_lo_r <= reg_wdata;
        ADDR_W'(SAS_ADDR_DAC): dac_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Flags: a hardware set in the same cycle beats the software clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctrl_r <= SAS_RST_REG;
    else
    begin
      if (wr_ctrl)
        ctrl_r[7:5] <= reg_wdata[7:5];
      if (wr_ctrl)
        ctrl_r[2:0] <= reg_wdata[2:0];
      if (done_evt)
        ctrl_r[SAS_CTRL_DONE] <= 1'b1;
      else if (wr_ctrl && !reg_wdata[SAS_CTRL_DONE])
        ctrl_r[SAS_CTRL_DONE] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mode_a_r <= SAS_RST_REG;
    else
    begin
      if (wr_mode_a)
        mode_a_r[6:4] <= reg_wdata[6:4];
      if (lim_evt)
        mode_a_r[SAS_MODEA_LIM_FLAG] <= 1'b1;
      else if (wr_mode_a && !reg_wdata[SAS_MODEA_LIM_FLAG])
        mode_a_r[SAS_MODEA_LIM_FLAG] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_W'(SAS_ADDR_CTRL): rdata_r <= ctrl_r & 8'hef;
        ADDR_W'(SAS_ADDR_MODE_A): rdata_r <= mode_a_r & 8'hf0;
        ADDR_W'(SAS_ADDR_MODE_B): rdata_r <= mode_b_r;
        ADDR_W'(SAS_ADDR_CHSEL): rdata_r <= chsel_r;
        ADDR_W'(SAS_ADDR_LIM_HI): rdata_r <= lim_hi_r;
        ADDR_W'(SAS_ADDR_LIM_LO): rdata_r <= lim_lo_r;
        ADDR_W'(SAS_ADDR_DAC): rdata_r <= dac_r;
        ADDR_W'(SAS_ADDR_RES0): rdata_r <= res_r[0];
        ADDR_W'(SAS_ADDR_RES0 + 8'h01): rdata_r <= res_r[1];
        ADDR_W'(SAS_ADDR_RES0 + 8'h02): rdata_r <= res_r[2];
        ADDR_W'(SAS_ADDR_RES0 + 8'h03): rdata_r <= res_r[3];
        default: rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sample_r <= 1'b0;
      busy_r <= 1'b0;
      dig_r <= 4'h0;
      dac_drive_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      sample_r <= (st_nxt == SAS_SAMPLE);
      busy_r <= (st_nxt != SAS_IDLE);
      dig_r <= chsel_r[7:4] & {4{ctrl_r[SAS_CTRL_EN]}};
      dac_drive_r <= ctrl_r[SAS_CTRL_EN] && mode_b_r[SAS_MODEB_DAC_OE];
      irq_r <= (ctrl_r[SAS_CTRL_DONE] && ctrl_r[SAS_CTRL_DONE_IE])
               || (mode_a_r[SAS_MODEA_LIM_FLAG] && ctrl_r[SAS_CTRL_LIM_IE]);
      wake_r <= idle_mode && ctrl_r[SAS_CTRL_DONE] && ctrl_r[SAS_CTRL_DONE_IE];
    end
  end

  assign reg_rdata = rdata_r;
  assign sample_hold = sample_r;
  assign mux_channel = ch_r;
  assign sar_trial = sar_r;
  assign busy = busy_r;
  assign dig_in_disconnect = dig_r;
  assign dac_output_pin = dac_r;
  assign dac_drive = dac_drive_r;
  assign irq_req = irq_r;
  assign idle_wake = wake_r;

  // ==========================================================
  // Checks
  a_now_starts: assert property (@(posedge clk_sys) disable iff (rst)
    (go && trig_now) |=> sample_hold ##0 busy)
    else $error("immediate start not taken");
  a_busy_ignores: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r == SAS_CONVERT && timer0_ovf && !conv_end) |=> st_r != SAS_SAMPLE)
    else $error("trigger restarted busy converter");
  a_done_sets: assert property (@(posedge clk_sys) disable iff (rst)
    done_evt |=> ctrl_r[SAS_CTRL_DONE])
    else $error("done flag not set");
  a_done_holds: assert property (@(posedge clk_sys) disable iff (rst)
    (ctrl_r[SAS_CTRL_DONE] && !wr_ctrl) |=> ctrl_r[SAS_CTRL_DONE])
    else $error("done flag lost without write");
  a_pd_stops: assert property (@(posedge clk_sys) disable iff (rst)
    (power_down && st_r != SAS_IDLE) |=> st_r == SAS_IDLE ##1 !busy)
    else $error("converter runs in power-down");
  a_step_halts: assert property (@(posedge clk_sys) disable iff (rst)
    (conv_end && mode == SAS_MD_STEP && run_ok && !stop_code) |=> st_r == SAS_IDLE)
    else $error("single step did not halt");
  a_done_irq: assert property (@(posedge clk_sys) disable iff (rst)
    (ctrl_r[SAS_CTRL_DONE] && ctrl_r[SAS_CTRL_DONE_IE]) |=> irq_req)
    else $error("done request missing");
  a_lim_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (!ctrl_r[SAS_CTRL_LIM_IE] && !ctrl_r[SAS_CTRL_DONE]) |=> !irq_req)
    else $error("limit request while disabled");
  a_lim_source: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(mode_a_r[SAS_MODEA_LIM_FLAG])
      |-> ($past(mode_b_r[SAS_MODEB_CHK_ALL]) || $past(ch_r) == 2'h0))
    else $error("limit flag from unchecked input");
  a_dig_cut: assert property (@(posedge clk_sys) disable iff (rst)
    !ctrl_r[SAS_CTRL_EN] |=> dig_in_disconnect == 4'h0)
    else $error("digital input cut while disabled");
endmodule : sas_sequencer

// ==== tb/sas_analog_model.sv ====
// Behavioural analog front end: input mux, sample-and-hold and comparator.
// Assumes the sequencer holds sample_hold high for the whole sample phase.
module sas_analog_model
(
  input wire logic clk_sys,
  input wire logic sample_hold,
  input wire logic [1:0] mux_channel,
  input wire logic [7:0] sar_trial,
  input wire logic [31:0] levels,
  output logic comp_ge
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] held_r;
  logic [7:0] live;
  // ==========================================================
  // Hold capacitor and comparator
  assign live = levels[8*mux_channel +: 8];
  always_ff @(posedge clk_sys)
  begin
    if (sample_hold)
    begin
      held_r <= live;
    end
  end
  // Input changes after sampling must not leak into the decisions
  assign comp_ge = ((sample_hold ? live : held_r) >= sar_trial);
endmodule : sas_analog_model

// ==== tb/tb_sar_adc_sequencer.sv ====
// Self-checking bench for the converter sequencer: registers, starts, modes, limits, DAC.
// Assumes sas_pkg, the sequencer and the analog front-end model are compiled first.
module tb_sar_adc_sequencer
  import sas_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic timer0_ovf = 1'b0;
  logic edge_trigger_pin = 1'b0;
  logic idle_mode = 1'b0;
  logic power_down = 1'b0;
  logic [31:0] lv = 32'hc3775a21;
  logic [7:0] reg_rdata, sar_trial, dac_output_pin;
  logic [3:0] dig_in_disconnect;
  logic [1:0] mux_channel;
  logic comp_ge, sample_hold, busy, dac_drive, irq_req, idle_wake;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int n, len0, len7;
  logic [7:0] tm [3] = '{8'h20, 8'h20, 8'h40};
  logic [7:0] tc [3] = '{8'h40, 8'h30, 8'h40};
  logic [31:0] te [3] = '{32'h77777777, 32'h5a215a21, 32'h5a775a21};
  logic [7:0] lb [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
  logic [7:0] lc [6] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h20, 8'h20};
  logic [31:0] ll [6] = '{32'hc0, 32'h85, 32'h50, 32'h1f, 32'hf000, 32'hf000};
  logic [7:0] lf [6] = '{8'h90, 8'h90, 8'h10, 8'h90, 8'h10, 8'h90};
  // ==========================================================
  // Design and far side
  sas_sequencer #(.ADDR_W(8)) u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer0_ovf(timer0_ovf), .edge_trigger_pin(edge_trigger_pin), .idle_mode(idle_mode),
    .power_down(power_down), .comp_ge(comp_ge), .sample_hold(sample_hold),
    .mux_channel(mux_channel), .sar_trial(sar_trial), .busy(busy),
    .dig_in_disconnect(dig_in_disconnect), .dac_output_pin(dac_output_pin),
    .dac_drive(dac_drive), .irq_req(irq_req), .idle_wake(idle_wake));
  sas_analog_model u_model (.clk_sys(clk_sys), .sample_hold(sample_hold),
    .mux_channel(mux_channel), .sar_trial(sar_trial), .levels(lv), .comp_ge(comp_ge));
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask : rd
  // Waits a few cycles for the start, then counts busy cycles
  task automatic busy_len(output int len);
    int k;
    k = 0;
    len = 0;
    #1;
    while (busy !== 1'b1 && k < 4)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    while (busy === 1'b1 && len < 2000)
    begin
      @(posedge clk_sys);
      #1;
      len++;
    end
    chk("busy_end", 8'h00, {7'h00, busy});
  endtask : busy_len
  task automatic pulse(input bit pin);
    @(posedge clk_sys);
    if (pin)
      edge_trigger_pin <= ~edge_trigger_pin;
    else
      timer0_ovf <= 1'b1;
    @(posedge clk_sys);
    timer0_ovf <= 1'b0;
  endtask : pulse
  // Second trigger lands mid-conversion; no extra conversion may follow
  task automatic trig_twice(input bit pin);
    fork
      begin
        pulse(pin);
        busy_len(n);
      end
      begin
        repeat (6) @(posedge clk_sys);
        pulse(pin);
      end
    join
    repeat (4) @(posedge clk_sys);
    #1;
    chk("busy_after", 8'h00, {7'h00, busy});
  endtask : trig_twice
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq_req !== 1'b1 && k < 400)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("irq_wait", 8'h01, {7'h00, irq_req});
  endtask : wait_irq
  task automatic close_out();
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      $display("unexpected cycle_count expected %0d seen %0d", 19999, cyc);
      close_out();
    end
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(SAS_ADDR_CTRL, SAS_RST_REG, "ctrl_reset");
    rd(SAS_ADDR_MODE_A, SAS_RST_REG, "mode_a_reset");
    rd(SAS_ADDR_LIM_HI, SAS_RST_LIM_HI, "lim_hi_reset");
    wr(SAS_ADDR_MODE_A, 8'hff);
    rd(SAS_ADDR_MODE_A, 8'h70, "mode_a_bits");
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00, "unmapped");
    wr(SAS_ADDR_MODE_A, 8'h00);
    wr(SAS_ADDR_CHSEL, 8'h3f);
    rd(SAS_ADDR_CHSEL, 8'h30, "chsel_bits");
    wr(SAS_ADDR_CTRL, 8'h64);
    trig_twice(1'b0);
    rd(SAS_ADDR_RES0, lv[7:0], "step_res0");
    pulse(1'b0);
    busy_len(n);
    rd(8'(SAS_ADDR_RES0 + 1), lv[15:8], "step_res1");
    wr(SAS_ADDR_CTRL, 8'h44);
    pulse(1'b0);
    busy_len(n);
    chk("stop_code", 8'h00, 8'(n));
    wr(SAS_ADDR_CHSEL, 8'h20);
    idle_mode <= 1'b1;
    wr(SAS_ADDR_CTRL, 8'h45);
    busy_len(len0);
    rd(8'(SAS_ADDR_RES0 + 1), lv[15:8], "imm_res1");
    rd(SAS_ADDR_CTRL, 8'h4d, "done_set");
    chk("irq_done", 8'h01, {7'h00, irq_req});
    chk("idle_wake", 8'h01, {7'h00, idle_wake});
    chk("dig_off", 8'h02, {4'h0, dig_in_disconnect});
    wr(SAS_ADDR_CTRL, 8'h44);
    idle_mode <= 1'b0;
    rd(SAS_ADDR_CTRL, 8'h44, "done_clear");
    chk("irq_clear", 8'h00, {7'h00, irq_req});
    // Slowest legal divisor setting
    wr(SAS_ADDR_MODE_B, 8'he0);
    wr(SAS_ADDR_CTRL, 8'h05);
    busy_len(len7);
    chk("div_span", 8'h3f, 8'(len7 - len0));
    wr(SAS_ADDR_MODE_B, 8'h00);
    wr(SAS_ADDR_MODE_A, 8'h10);
    wr(SAS_ADDR_CHSEL, 8'hf0);
    wr(SAS_ADDR_CTRL, 8'h07);
    trig_twice(1'b1);
    for (int i = 0; i < 4; i++)
      rd(8'(SAS_ADDR_RES0 + i), lv[8*i +: 8], "pass_res");
    rd(SAS_ADDR_CTRL, 8'h0f, "pass_done");
    chk("dig_all", 8'h0f, {4'h0, dig_in_disconnect});
    for (int t = 0; t < 3; t++)
    begin
      wr(SAS_ADDR_MODE_A, tm[t]);
      wr(SAS_ADDR_CHSEL, tc[t]);
      wr(SAS_ADDR_CTRL, 8'h45);
      wait_irq();
      chk("still_busy", 8'h01, {7'h00, busy});
      wr(SAS_ADDR_CTRL, 8'h44);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("stopped", 8'h00, {7'h00, busy});
      for (int i = 0; i < 4; i++)
        rd(8'(SAS_ADDR_RES0 + i), te[t][8*i +: 8], "cont_res");
    end
    wr(SAS_ADDR_CTRL, 8'h05);
    repeat (3) @(posedge clk_sys);
    power_down <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("pd_abort", 8'h00, {7'h00, busy});
    wr(SAS_ADDR_CTRL, 8'h05);
    busy_len(n);
    chk("pd_block", 8'h00, 8'(n));
    wr(SAS_ADDR_CTRL, 8'h04);
    power_down <= 1'b0;
    wr(SAS_ADDR_DAC, 8'h3c);
    wr(SAS_ADDR_MODE_B, 8'h08);
    rd(SAS_ADDR_MODE_B, 8'h08, "mode_b");
    chk("dac_value", 8'h3c, dac_output_pin);
    chk("dac_on", 8'h01, {7'h00, dac_drive});
    wr(SAS_ADDR_CTRL, 8'h00);
    rd(SAS_ADDR_CTRL, 8'h00, "ctrl_off");
    chk("dac_off", 8'h00, {7'h00, dac_drive});
    // Enable first: a start write only counts once the converter is on
    wr(SAS_ADDR_CTRL, 8'h04);
    wr(SAS_ADDR_LIM_HI, 8'h80);
    wr(SAS_ADDR_LIM_LO, 8'h20);
    // Single pass per row; rewriting mode A also clears the flag
    for (int t = 0; t < 6; t++)
    begin
      wr(SAS_ADDR_MODE_A, 8'h10);
      wr(SAS_ADDR_MODE_B, lb[t]);
      wr(SAS_ADDR_CHSEL, lc[t]);
      lv <= ll[t];
      wr(SAS_ADDR_CTRL, 8'h85);
      busy_len(n);
      rd(SAS_ADDR_MODE_A, lf[t], "limit_flag");
    end
    chk("irq_limit", 8'h01, {7'h00, irq_req});
    wr(SAS_ADDR_CTRL, 8'h04);
    rd(SAS_ADDR_CTRL, 8'h04, "lim_ie_off");
    chk("irq_masked", 8'h00, {7'h00, irq_req});
    close_out();
  end
endmodule : tb_sar_adc_sequencer
